// ### design/hub_port_cfg.v
`include "hub_port_cfg_defs.vh"
module hub_port_cfg (
    pclk,
    presetn,
    clk_en,
    psel,
    penable,
    pwrite,
    paddr,
    pwdata,
    prdata,
    pready,
    pslverr,
    port_off_straps,
    self_pwr_port_mask,
    remap_port_off,
    port_off,
    port_count,
    log1_phys_port,
    log2_phys_port,
    self_pwr_current_budget,
    bus_pwr_current_budget
);
    input wire pclk;
    input wire presetn;
    input wire clk_en;
    input wire psel;
    input wire penable;
    input wire pwrite;
    input wire [11:0] paddr;
    input wire [31:0] pwdata;
    output reg [31:0] prdata;
    output wire pready;
    output wire pslverr;
    input wire [1:0] port_off_straps;
    input wire [1:0] self_pwr_port_mask;
    input wire [1:0] remap_port_off;
    output reg [1:0] port_off;
    output reg [1:0] port_count;
    output reg [1:0] log1_phys_port;
    output reg [1:0] log2_phys_port;
    output wire [7:0] self_pwr_current_budget;
    output wire [7:0] bus_pwr_current_budget;

    reg [7:0] port_disable_bus_powered_q;
    reg [7:0] max_power_self_powered_q;
    reg [7:0] max_power_bus_powered_q;
    reg [7:0] ctrl_q;
    reg [1:0] strap_s1_q;
    reg [1:0] strap_s2_q;
    reg [31:0] rdata_d;
    wire [7:0] idx;
    wire wr;
    wire rd_setup;
    wire [1:0] off_d;
    wire [1:0] count_d;
    wire [1:0] l1_d;
    wire [1:0] l2_d;

    // ======================================================================
    // Bus slave
    // Zero wait states; unmapped indices read zero and ignore writes.
    assign pready = `PREADY_ALWAYS;
    assign pslverr = `PSLVERR_OK;
    assign idx = paddr[`ADDR_IDX_MSB:`ADDR_IDX_LSB];
    assign wr = psel & penable & pwrite & clk_en;
    assign rd_setup = psel & ~penable & ~pwrite & clk_en;
    assign self_pwr_current_budget = max_power_self_powered_q;
    assign bus_pwr_current_budget = max_power_bus_powered_q;

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            port_disable_bus_powered_q <= `REG_RESET;
            max_power_self_powered_q <= `REG_RESET; // R6
            max_power_bus_powered_q <= `REG_RESET; // R7
            ctrl_q <= `CTRL_RESET;
        end else if (wr) begin
            case (idx)
                `PORT_DISABLE_BUS_POWERED_IDX: begin
                    port_disable_bus_powered_q <= pwdata[`REG_MSB:0] &
                        `PORT_MASK_BITS; // R12
                end
                `MAX_POWER_SELF_POWERED_IDX: begin
                    max_power_self_powered_q <= pwdata[`REG_MSB:0]; // R6
                end
                `MAX_POWER_BUS_POWERED_IDX: begin
                    max_power_bus_powered_q <= pwdata[`REG_MSB:0]; // R7
                end
                `MODE_CTRL_IDX: begin
                    ctrl_q <= pwdata[`REG_MSB:0] & `CTRL_MASK;
                end
                default: begin
                    ctrl_q <= ctrl_q;
                end
            endcase
        end
    end

    always @* begin
        rdata_d = `RDATA_RESET;
        case (idx)
            `PORT_DISABLE_BUS_POWERED_IDX: begin
                rdata_d[`REG_MSB:0] = port_disable_bus_powered_q; // R12
            end
            `MAX_POWER_SELF_POWERED_IDX: begin
                rdata_d[`REG_MSB:0] = max_power_self_powered_q;
            end
            `MAX_POWER_BUS_POWERED_IDX: begin
                rdata_d[`REG_MSB:0] = max_power_bus_powered_q;
            end
            `MODE_CTRL_IDX: begin
                rdata_d[`REG_MSB:0] = ctrl_q;
            end
            `PORT_STATUS_IDX: begin
                rdata_d[`REG_MSB:0] = {log2_phys_port, log1_phys_port,
                                       port_count, port_off};
            end
            default: begin
                rdata_d = `RDATA_RESET;
            end
        endcase
    end

    // Read data is captured at the end of the setup phase and then stands
    // through the access phase, so no wait state is needed.
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= `RDATA_RESET;
        end else if (rd_setup) begin
            prdata <= rdata_d;
        end
    end

    // ======================================================================
    // Strap synchroniser
    // Straps come from pins, so they pass two flops before use.
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            strap_s1_q <= `STRAP_RESET;
            strap_s2_q <= `STRAP_RESET;
        end else if (clk_en) begin
            strap_s1_q <= port_off_straps;
            strap_s2_q <= strap_s1_q;
        end
    end

    // ======================================================================
    // Port selection and renumbering
    port_off_select i_port_off_select (
        .bus_powered(ctrl_q[`CTRL_BUS_PWR_BIT]),
        .renumber_sel(ctrl_q[`CTRL_RENUM_BIT]),
        .use_default(ctrl_q[`CTRL_DEFAULT_BIT]),
        .straps(strap_s2_q),
        .bus_pwr_port_off_mask(port_disable_bus_powered_q),
        .self_pwr_mask(self_pwr_port_mask),
        .remap_off(remap_port_off),
        .off(off_d)
    );

    port_renumber i_port_renumber (
        .off(off_d),
        .port_count(count_d),
        .phys_of_log1(l1_d),
        .phys_of_log2(l2_d)
    );

    // Registered so descriptor logic sees glitch-free values.
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            port_off <= `PORT_OFF_RESET;
            port_count <= `PORT_COUNT_RESET;
            log1_phys_port <= `LOG1_RESET;
            log2_phys_port <= `LOG2_RESET;
        end else if (clk_en) begin
            port_off <= off_d; // R2
            port_count <= count_d; // R3
            log1_phys_port <= l1_d; // R4
            log2_phys_port <= l2_d; // R4
        end
    end
endmodule // hub_port_cfg

// ### design/hub_port_cfg_defs.vh
// What this block does
// R1: In the bus-powered port disable register, bit 1 set turns off port 1 and bit 2 set turns off port 2, zero leaves a port available, and the other bits are reserved.
// R2: The bus-powered disable selection acts only in bus-powered operation with renumbering off, and a selected port then stays off for the host.
// R3: Ports may be turned off in any combination and the reported port count equals the ports left enabled.
// R4: When a lower port is off the remaining ports are renumbered so the host sees contiguous numbers.
// R5: With the internal default configuration the two port-off strap inputs decide which ports are off instead of the register.
//     The code gives renumbering select priority, so the remap table decides when both are set.
// R6: The self-powered current budget register holds the upstream current in 2 mA units and resets to zero.
// R7: The bus-powered current budget register holds the upstream current in 2 mA units and resets to zero.
// R8: Software sets each budget to cover the hub silicon and all board circuitry fed from the upstream supply.
// R9: For a compound device whose peripheral reports zero current, software adds that peripheral to the budgets.
// R10: Software keeps the self-powered budget at or below 100 mA.
// R11: With renumbering select set, numbering and disabling follow the separate remap table instead of the disable registers.
// R12: Reserved bits of the port disable register are ignored by the port logic and read back as zero.
`ifndef HUB_PORT_CFG_DEFS_VH
`define HUB_PORT_CFG_DEFS_VH
// ==========================================================================
// Register map
`define PORT_DISABLE_BUS_POWERED_IDX 8'h0b
`define MAX_POWER_SELF_POWERED_IDX 8'h0c
`define MAX_POWER_BUS_POWERED_IDX 8'h0d
`define MODE_CTRL_IDX 8'h20
`define PORT_STATUS_IDX 8'h21
`define ADDR_IDX_LSB 2
`define ADDR_IDX_MSB 9
// ==========================================================================
// Fields and reset values
`define PORT_MASK_BITS 8'h06
`define PORT1_BIT 1
`define PORT2_BIT 2
`define CTRL_BUS_PWR_BIT 0
`define CTRL_RENUM_BIT 1
`define CTRL_DEFAULT_BIT 2
`define CTRL_MASK 8'h07
`define REG_RESET 8'h00
`define CTRL_RESET 8'h00
`define PSLVERR_OK 1'h0
`define PREADY_ALWAYS 1'h1
`define REG_MSB 7
`define PORT_OFF_RESET 2'h0
`define PORT_COUNT_RESET 2'h2
`define LOG1_RESET 2'h1
`define LOG2_RESET 2'h2
`define STRAP_RESET 2'h0
`define RDATA_RESET 32'h0000_0000
`endif

// ### design/port_off_select.v
`include "hub_port_cfg_defs.vh"
module port_off_select (
    bus_powered,
    renumber_sel,
    use_default,
    straps,
    bus_pwr_port_off_mask,
    self_pwr_mask,
    remap_off,
    off
);
    input wire bus_powered;
    input wire renumber_sel;
    input wire use_default;
    input wire [1:0] straps;
    input wire [7:0] bus_pwr_port_off_mask;
    input wire [1:0] self_pwr_mask;
    input wire [1:0] remap_off;
    output reg [1:0] off;
    // ======================================================================
    // Port off selection
    always @* begin
        if (renumber_sel) begin
            off = remap_off; // R11
        end else if (use_default) begin
            off = straps; // R5
        end else if (bus_powered) begin
            // Only bits 1 and 2 matter; reserved bits never reach a port.
            off = {bus_pwr_port_off_mask[`PORT2_BIT],
                   bus_pwr_port_off_mask[`PORT1_BIT]}; // R1 R2 R12
        end else begin
            off = self_pwr_mask;
        end
    end
endmodule // port_off_select

// ### design/port_renumber.v
module port_renumber (
    off,
    port_count,
    phys_of_log1,
    phys_of_log2
);
    input wire [1:0] off;
    output wire [1:0] port_count;
    output wire [1:0] phys_of_log1;
    output wire [1:0] phys_of_log2;
    // ======================================================================
    // Count and contiguous numbering
    assign port_count = {1'h0, ~off[0]} + {1'h0, ~off[1]}; // R3
    // Logical port 1 is the lowest enabled physical port, zero means none.
    assign phys_of_log1 = !off[0] ? 2'h1 : (!off[1] ? 2'h2 : 2'h0); // R4
    assign phys_of_log2 = (off == 2'h0) ? 2'h2 : 2'h0; // R4
endmodule // port_renumber

// ### verif/hub_port_cfg_props.sv
module hub_port_cfg_props (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic clk_en,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic [1:0] port_off_straps,
    input wire logic [1:0] self_pwr_port_mask,
    input wire logic [1:0] remap_port_off,
    input wire logic [1:0] port_off,
    input wire logic [1:0] port_count,
    input wire logic [1:0] log1_phys_port,
    input wire logic [1:0] log2_phys_port,
    input wire logic [7:0] self_pwr_current_budget,
    input wire logic [7:0] bus_pwr_current_budget
);
    timeunit 1ns;
    timeprecision 1ps;
    // ========================================================================
    // Shadow of the mode and port disable registers
    logic [7:0] mode_q, disable_q;
    logic [1:0] e;
    logic wr;
    assign wr = psel && penable && pwrite && clk_en;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mode_q <= 8'h00;
            disable_q <= 8'h00;
        end else if (wr) begin
            if (paddr[9:2] == 8'h20) mode_q <= pwdata[7:0];
            if (paddr[9:2] == 8'h0b) disable_q <= pwdata[7:0];
        end
    end
    always_comb begin
        if (mode_q[1]) e = remap_port_off;
        else if (mode_q[2]) e = port_off_straps;
        else if (mode_q[0]) e = disable_q[2:1];
        else e = self_pwr_port_mask;
    end
    // ========================================================================
    // Properties
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    count_match_a: assert property (
        port_count == 2'd2 - port_off[0] - port_off[1])
        else $error("port count wrong");
    renum_low_a: assert property (
        port_off == 2'b01 |->
        log1_phys_port == 2'd2 && log2_phys_port == 2'd0)
        else $error("renumber");
    plain_order_a: assert property (
        port_off == 2'b00 |->
        log1_phys_port == 2'd1 && log2_phys_port == 2'd2)
        else $error("order");
    off_select_a: assert property (
        ($stable(e) && clk_en && (!mode_q[2] || mode_q[1]))[*3] |->
        port_off == e)
        else $error("port off");
    strap_select_a: assert property (
        ($stable(e) && clk_en && mode_q[2] && !mode_q[1])[*5] |->
        port_off == e)
        else $error("straps");
    self_budget_a: assert property (
        wr && paddr == 12'h030 ##1 clk_en |=>
        {24'h0, self_pwr_current_budget} ==
        ($past(pwdata, 2) & 32'h0000_00ff))
        else $error("sp budget");
    bus_budget_a: assert property (
        wr && paddr == 12'h034 ##1 clk_en |=>
        {24'h0, bus_pwr_current_budget} ==
        ($past(pwdata, 2) & 32'h0000_00ff))
        else $error("bp budget");
    rsvd_zero_a: assert property (
        psel && penable && !pwrite && paddr == 12'h02c |->
        (prdata & 32'hffff_fff9) == 32'h0)
        else $error("rsvd");
    cover property (port_off == 2'b11);
    cover property (mode_q[1] && port_off == 2'b01);
    cover property (mode_q[2] && port_off == 2'b10);
endmodule // hub_port_cfg_props
bind hub_port_cfg hub_port_cfg_props i_hub_port_cfg_props (.*);

// ### verif/upstream_host.sv
module upstream_host (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [1:0] port_count,
    input wire logic [1:0] log1,
    input wire logic [1:0] log2,
    output logic [1:0] seen
);
    timeunit 1ns;
    timeprecision 1ps;
    // The host stops at the first gap, so holes in numbering are not seen.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) seen <= 2'd0;
        else seen <= {1'b0, log1 != 0 && port_count > 0} +
            {1'b0, log2 != 0 && port_count > 1 && log1 != 0};
    end
endmodule // upstream_host

// ### verif/hub_port_cfg_bench.sv
module hub_port_cfg_bench;
    timeunit 1ns;
    timeprecision 1ps;
    logic pclk = 0, presetn = 0, clk_en = 1, psel = 0, penable = 0, pwrite = 0;
    logic [11:0] paddr = 0;
    logic [31:0] pwdata = 0, prdata, r;
    logic pready, pslverr, perr;
    logic [1:0] straps = 0, spm = 0, rpo = 0, off, cnt, l1, l2, seen;
    logic [7:0] spb, bpb;
    int errors = 0, checks = 0;
    initial forever #4 pclk = ~pclk;
    hub_port_cfg i_hub_port_cfg (.pclk(pclk), .presetn(presetn),
        .clk_en(clk_en), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .port_off_straps(straps), .self_pwr_port_mask(spm),
        .remap_port_off(rpo), .port_off(off), .port_count(cnt),
        .log1_phys_port(l1), .log2_phys_port(l2),
        .self_pwr_current_budget(spb), .bus_pwr_current_budget(bpb));
    upstream_host i_upstream_host (.pclk(pclk), .presetn(presetn),
        .port_count(cnt), .log1(l1), .log2(l2), .seen(seen));
    // ========================================================================
    // Tasks
    task automatic summarize;
        $display("errors %0d checks %0d", errors, checks);
        if (errors == 0 && checks > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            errors++;
            $display("FAIL %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        psel <= 1;
        penable <= 0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1;
        n = 0;
        do begin @(posedge pclk); n++; end while (pready !== 1'b1 && n < 50);
        if (n >= 50) errors++;
        r = prdata;
        perr = pslverr;
        psel <= 0;
        penable <= 0;
        // One idle edge keeps two calls from driving psel twice at once.
        @(posedge pclk);
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        chk(r, e);
    endtask
    // Straps pass a two-stage synchroniser, so five edges cover every path.
    task automatic ports(input logic [1:0] o);
        logic [1:0] n;
        n = 2'd2 - o[0] - o[1];
        repeat (5) @(posedge pclk);
        chk({off, cnt, l1, l2, seen}, {o, n,
            o[0] ? (o[1] ? 2'd0 : 2'd2) : 2'd1,
            o == 2'd0 ? 2'd2 : 2'd0, n});
    endtask
    // ========================================================================
    // Tests
    initial begin
        repeat (3) @(posedge pclk);
        presetn <= 1;
        @(posedge pclk);
        rd(12'h02c, 32'h0);
        rd(12'h030, 32'h0);
        rd(12'h034, 32'h0);
        wr(12'h02c, 32'hffff_ffff);
        rd(12'h02c, 32'h0000_0006);
        wr(12'h080, 32'h0000_0001);
        for (int i = 0; i < 4; i++) begin
            wr(12'h02c, i * 2);
            ports(i[1:0]);
        end
        spm <= 2'b10;
        wr(12'h080, 32'h0000_0000);
        ports(2'b10);
        rpo <= 2'b01;
        wr(12'h080, 32'h0000_0003);
        ports(2'b01);
        rd(12'h080, 32'h0000_0003);
        rd(12'h084, 32'h0000_0025);
        straps <= 2'b10;
        wr(12'h080, 32'h0000_0005);
        ports(2'b10);
        wr(12'h030, 32'h0000_0032);
        wr(12'h034, 32'h0000_00fa);
        repeat (2) @(posedge pclk);
        chk({spb, bpb}, 32'h0000_32fa);
        clk_en <= 0;
        wr(12'h030, 32'h0000_0011);
        clk_en <= 1;
        rd(12'h030, 32'h0000_0032);
        rd(12'h040, 32'h0);
        chk({31'h0, perr}, 32'h0);
        summarize;
    end
    initial begin
        #20000;
        errors++;
        summarize;
    end
endmodule // hub_port_cfg_bench
